// File: tcr_timing_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module tcr_timing_config_regs (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic clock_enable_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic reg_rmw_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [7:0] timer1_count_hi_in,
   input wire logic timer1_count_hi_load_in,
   input wire logic wdog_kick_in,
   input wire logic move_start_in,
   input wire logic move_write_in,
   input wire logic move_onchip_in,
   input wire logic machine_cycle_in,
   output logic move_rd_n_out,
   output logic move_wr_n_out,
   output logic move_busy_out,
   input wire logic [7:0] port1_pins_in,
   output logic [7:0] port1_drive_out,
   output logic [7:0] analog_input_channels_out,
   output logic timer2_count_pin_out,
   output logic timer2_capture_trigger_out,
   output logic port0_pullup_enable_out,
   output logic timer0_tick_out,
   output logic timer1_tick_out,
   output logic timer2_tick_out,
   output logic wdog_int_timeout_out,
   output logic wdog_rst_timeout_out,
   output logic irq_out
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] clock_stretch_ctrl_r;
   logic [7:0] port0_pullup_reg_r;
   logic [7:0] port1_latch_r;
   logic [7:0] timer1_upper_count_r;
   logic [7:0] reg_rdata_r;
   logic [2:0] irq_status_r;
   logic [2:0] irq_enable_r;
   logic [7:0] pins_meta_r;
   logic [7:0] pins_sync_r;

   wire ce = clock_enable_in;
   wire wr_timer1 = reg_write_in && reg_addr_in == tcr_pkg::TCR_ADDR_TIMER1_UPPER;
   wire wr_clock = reg_write_in && reg_addr_in == tcr_pkg::TCR_ADDR_CLOCK_STRETCH;
   wire wr_pullup = reg_write_in && reg_addr_in == tcr_pkg::TCR_ADDR_PORT0_PULLUP;
   wire wr_port1 = reg_write_in && reg_addr_in == tcr_pkg::TCR_ADDR_PORT1;
   wire wr_irq_en = reg_write_in && reg_addr_in == tcr_pkg::TCR_ADDR_IRQ_ENABLE;
   wire wr_irq_clr = reg_write_in && reg_addr_in == tcr_pkg::TCR_ADDR_IRQ_CLEAR;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         clock_stretch_ctrl_r <= tcr_pkg::TCR_RST_CLOCK_STRETCH;
         port0_pullup_reg_r <= tcr_pkg::TCR_RST_PORT0_PULLUP;
         port1_latch_r <= tcr_pkg::TCR_RST_PORT1;
         irq_enable_r <= tcr_pkg::TCR_RST_IRQ;
      end else if (ce) begin
         if (wr_clock) begin
            clock_stretch_ctrl_r <= reg_wdata_in;
         end
         if (wr_pullup) begin
            port0_pullup_reg_r <= {7'h00, reg_wdata_in[tcr_pkg::TCR_PULLUP_BIT]};
         end
         if (wr_port1) begin
            port1_latch_r <= reg_wdata_in;
         end
         if (wr_irq_en) begin
            irq_enable_r <= reg_wdata_in[2:0];
         end
      end
   end

   // Software write wins over a timer load in the same cycle
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         timer1_upper_count_r <= tcr_pkg::TCR_RST_TIMER1_UPPER;
      end else if (ce) begin
         if (wr_timer1) begin
            timer1_upper_count_r <= reg_wdata_in;
         end else if (timer1_count_hi_load_in) begin
            timer1_upper_count_r <= timer1_count_hi_in;
         end
      end
   end

   // ----------------------------------------
   // Pin synchroniser
   // ----------------------------------------
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         pins_meta_r <= 8'h00;
         pins_sync_r <= 8'h00;
      end else if (ce) begin
         pins_meta_r <= port1_pins_in;
         pins_sync_r <= pins_meta_r;
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire [7:0] port1_read = reg_rmw_in ? port1_latch_r : pins_sync_r;
   logic [7:0] rdata_nxt;
   always_comb begin
      case (reg_addr_in)
         tcr_pkg::TCR_ADDR_TIMER1_UPPER: rdata_nxt = timer1_upper_count_r;
         tcr_pkg::TCR_ADDR_CLOCK_STRETCH: rdata_nxt = clock_stretch_ctrl_r;
         tcr_pkg::TCR_ADDR_PORT0_PULLUP: rdata_nxt = port0_pullup_reg_r;
         tcr_pkg::TCR_ADDR_PORT1: rdata_nxt = port1_read;
         tcr_pkg::TCR_ADDR_IRQ_STATUS: rdata_nxt = {5'h00, irq_status_r};
         tcr_pkg::TCR_ADDR_IRQ_ENABLE: rdata_nxt = {5'h00, irq_enable_r};
         default: rdata_nxt = 8'h00;
      endcase
   end
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         reg_rdata_r <= 8'h00;
      end else if (ce) begin
         reg_rdata_r <= reg_read_in ? rdata_nxt : 8'h00;
      end
   end
   assign reg_rdata_out = reg_rdata_r;

   // ----------------------------------------
   // Port pins and alternate functions
   // ----------------------------------------
   assign port1_drive_out = port1_latch_r;
   assign analog_input_channels_out = pins_sync_r;
   assign timer2_count_pin_out = pins_sync_r[tcr_pkg::TCR_T2_COUNT_PIN];
   assign timer2_capture_trigger_out = pins_sync_r[tcr_pkg::TCR_T2_TRIG_PIN];
   assign port0_pullup_enable_out = port0_pullup_reg_r[tcr_pkg::TCR_PULLUP_BIT];

   // ----------------------------------------
   // Timer prescalers
   // ----------------------------------------
   tcr_prescaler u_pre0 (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .enable_in(ce),
      .fast_sel_in(clock_stretch_ctrl_r[tcr_pkg::TCR_T0_SEL_BIT]),
      .tick_out(timer0_tick_out)
   );
   tcr_prescaler u_pre1 (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .enable_in(ce),
      .fast_sel_in(clock_stretch_ctrl_r[tcr_pkg::TCR_T1_SEL_BIT]),
      .tick_out(timer1_tick_out)
   );
   tcr_prescaler u_pre2 (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .enable_in(ce),
      .fast_sel_in(clock_stretch_ctrl_r[tcr_pkg::TCR_T2_SEL_BIT]),
      .tick_out(timer2_tick_out)
   );

   // ----------------------------------------
   // Watchdog time-outs
   // ----------------------------------------
   wire [1:0] wdog_sel = {clock_stretch_ctrl_r[tcr_pkg::TCR_WDOG_HI_BIT],
                          clock_stretch_ctrl_r[tcr_pkg::TCR_WDOG_LO_BIT]};
   tcr_wdog_timeout u_wdog (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .enable_in(ce),
      .kick_in(wdog_kick_in),
      .period_sel_in(wdog_sel),
      .int_timeout_out(wdog_int_timeout_out),
      .rst_timeout_out(wdog_rst_timeout_out)
   );

   // ----------------------------------------
   // External data move strobe stretch
   // ----------------------------------------
   tcr_pkg::tcr_move_state_t mv_state_r;
   tcr_pkg::tcr_move_state_t mv_state_nxt;
   logic [3:0] mv_left_r;
   logic [3:0] mv_left_nxt;
   logic mv_is_write_r;
   logic mv_strobe_r;
   wire [2:0] stretch = clock_stretch_ctrl_r[tcr_pkg::TCR_STRETCH_MSB:0];
   // On-chip SRAM needs no extra cycles
   wire [3:0] mv_len = move_onchip_in ? tcr_pkg::TCR_MOVE_BASE_CYCLES
                       : tcr_pkg::TCR_MOVE_BASE_CYCLES + {1'b0, stretch};
   always_comb begin
      mv_state_nxt = mv_state_r;
      mv_left_nxt = mv_left_r;
      case (mv_state_r)
         tcr_pkg::TCR_MV_IDLE: begin
            if (move_start_in) begin
               mv_state_nxt = tcr_pkg::TCR_MV_STROBE;
               mv_left_nxt = mv_len;
            end
         end
         tcr_pkg::TCR_MV_STROBE: begin
            if (machine_cycle_in) begin
               mv_left_nxt = mv_left_r - 4'h1;
               if (mv_left_r == 4'h1) begin
                  mv_state_nxt = tcr_pkg::TCR_MV_DONE;
               end
            end
         end
         tcr_pkg::TCR_MV_DONE: mv_state_nxt = tcr_pkg::TCR_MV_IDLE;
         default: mv_state_nxt = tcr_pkg::TCR_MV_IDLE;
      endcase
   end
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         mv_state_r <= tcr_pkg::TCR_MV_IDLE;
         mv_left_r <= 4'h0;
         mv_is_write_r <= 1'b0;
         mv_strobe_r <= 1'b0;
      end else if (ce) begin
         mv_state_r <= mv_state_nxt;
         mv_left_r <= mv_left_nxt;
         mv_strobe_r <= (mv_state_nxt == tcr_pkg::TCR_MV_STROBE) && !move_onchip_in;
         if (mv_state_r == tcr_pkg::TCR_MV_IDLE && move_start_in) begin
            mv_is_write_r <= move_write_in;
         end
      end
   end
   // Strobes only reach the pins for off-chip targets
   assign move_rd_n_out = ~(mv_strobe_r & ~mv_is_write_r);
   assign move_wr_n_out = ~(mv_strobe_r & mv_is_write_r);
   assign move_busy_out = (mv_state_r == tcr_pkg::TCR_MV_STROBE);

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   wire [2:0] irq_events = {mv_state_r == tcr_pkg::TCR_MV_DONE,
                            wdog_rst_timeout_out, wdog_int_timeout_out};
   wire [2:0] irq_clear = wr_irq_clr ? reg_wdata_in[2:0] : 3'h0;
   // Set beats clear in the same cycle
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         irq_status_r <= tcr_pkg::TCR_RST_IRQ;
      end else if (ce) begin
         irq_status_r <= (irq_status_r & ~irq_clear) | irq_events;
      end
   end
   assign irq_out = |(irq_status_r & irq_enable_r);
endmodule
`default_nettype wire

// File: tcr_pkg.sv
package tcr_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] TCR_ADDR_TIMER1_UPPER = 8'h8d;
   localparam logic [7:0] TCR_ADDR_CLOCK_STRETCH = 8'h8e;
   localparam logic [7:0] TCR_ADDR_PORT0_PULLUP = 8'h8f;
   localparam logic [7:0] TCR_ADDR_PORT1 = 8'h90;
   localparam logic [7:0] TCR_ADDR_IRQ_STATUS = 8'hf0;
   localparam logic [7:0] TCR_ADDR_IRQ_ENABLE = 8'hf1;
   localparam logic [7:0] TCR_ADDR_IRQ_CLEAR = 8'hf2;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int TCR_WDOG_HI_BIT = 7;
   localparam int TCR_WDOG_LO_BIT = 6;
   localparam int TCR_T2_SEL_BIT = 5;
   localparam int TCR_T1_SEL_BIT = 4;
   localparam int TCR_T0_SEL_BIT = 3;
   localparam int TCR_STRETCH_MSB = 2;
   localparam int TCR_PULLUP_BIT = 0;
   localparam int TCR_T2_COUNT_PIN = 1;
   localparam int TCR_T2_TRIG_PIN = 0;
   localparam int TCR_IRQ_WDOG_INT = 0;
   localparam int TCR_IRQ_WDOG_RST = 1;
   localparam int TCR_IRQ_MOVE_DONE = 2;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] TCR_RST_CLOCK_STRETCH = 8'h01;
   localparam logic [7:0] TCR_RST_PORT0_PULLUP = 8'h00;
   localparam logic [7:0] TCR_RST_PORT1 = 8'hff;
   localparam logic [7:0] TCR_RST_TIMER1_UPPER = 8'h00;
   localparam logic [2:0] TCR_RST_IRQ = 3'h0;
   // ----------------------------------------
   // Timing counts
   // ----------------------------------------
   localparam int TCR_WDOG_RESET_EXTRA = 512;
   localparam logic [4:0] TCR_WDOG_EXP0 = 5'h11;
   localparam logic [4:0] TCR_WDOG_EXP1 = 5'h14;
   localparam logic [4:0] TCR_WDOG_EXP2 = 5'h17;
   localparam logic [4:0] TCR_WDOG_EXP3 = 5'h1a;
   localparam logic [3:0] TCR_DIV_FAST = 4'h4;
   localparam logic [3:0] TCR_DIV_SLOW = 4'hc;
   localparam logic [3:0] TCR_MOVE_BASE_CYCLES = 4'h2;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TCR_MV_IDLE = 2'b00,
      TCR_MV_STROBE = 2'b01,
      TCR_MV_DONE = 2'b10
   } tcr_move_state_t;

   // Interrupt time-out as a 27-bit count
   function automatic logic [26:0] tcr_wdog_timeout(input logic [1:0] code);
      logic [4:0] e;
      e = TCR_WDOG_EXP0;
      case (code)
         2'b00: e = TCR_WDOG_EXP0;
         2'b01: e = TCR_WDOG_EXP1;
         2'b10: e = TCR_WDOG_EXP2;
         2'b11: e = TCR_WDOG_EXP3;
         default: e = TCR_WDOG_EXP0;
      endcase
      return 27'h1 << e;
   endfunction
endpackage

// File: tcr_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tcr_prescaler (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic fast_sel_in,
   output logic tick_out
);
   logic [3:0] count_r;
   logic [3:0] count_nxt;
   wire [3:0] limit = fast_sel_in ? tcr_pkg::TCR_DIV_FAST : tcr_pkg::TCR_DIV_SLOW;
   wire wrap = (count_r >= limit - 4'h1);
   assign count_nxt = wrap ? 4'h0 : count_r + 4'h1;
   // One tick per 4 or 12 clocks
   assign tick_out = enable_in & wrap;
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         count_r <= 4'h0;
      end else if (enable_in) begin
         count_r <= count_nxt;
      end
   end
endmodule
`default_nettype wire

// File: tcr_wdog_timeout.sv
`timescale 1ns/100ps
`default_nettype none
module tcr_wdog_timeout (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic kick_in,
   input wire logic [1:0] period_sel_in,
   output logic int_timeout_out,
   output logic rst_timeout_out
);
   logic [27:0] count_r;
   wire [26:0] int_limit = tcr_pkg::tcr_wdog_timeout(period_sel_in);
   wire [27:0] int_at = {1'b0, int_limit};
   wire [27:0] rst_at = int_at + 28'(tcr_pkg::TCR_WDOG_RESET_EXTRA);
   // Pulses at the exact counts
   assign int_timeout_out = enable_in & (count_r == int_at);
   assign rst_timeout_out = enable_in & (count_r == rst_at);
   // Parks one past the reset count, so each time-out is a single pulse
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         count_r <= 28'h0;
      end else if (enable_in && kick_in) begin
         count_r <= 28'h0;
      end else if (enable_in && count_r <= rst_at) begin
         count_r <= count_r + 28'h1;
      end
   end
endmodule
`default_nettype wire

// File: tcr_ext_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// Slow peripheral: paces machine cycles and times the move strobes
module tcr_ext_mem_model (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic busy_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   output logic machine_cycle_out,
   output logic [3:0] busy_mc_out,
   output logic [3:0] strobe_mc_out,
   output logic saw_wr_out
);
   logic [1:0] phase_r;
   logic busy_q;
   logic low;
   assign machine_cycle_out = (phase_r == 2'h3);
   assign low = !(rd_n_in && wr_n_in);
   // Four clocks a machine cycle, so a long stretch really is slow
   always @(posedge clock_in) begin
      phase_r <= reset_in ? 2'h0 : phase_r + 2'h1;
      busy_q <= busy_in;
      if (reset_in || (busy_in && !busy_q)) begin
         busy_mc_out <= {3'h0, machine_cycle_out};
         strobe_mc_out <= {3'h0, machine_cycle_out && low};
         saw_wr_out <= !wr_n_in;
      end else begin
         busy_mc_out <= busy_mc_out + {3'h0, busy_in && machine_cycle_out};
         strobe_mc_out <= strobe_mc_out + {3'h0, low && machine_cycle_out};
         saw_wr_out <= saw_wr_out || !wr_n_in;
      end
   end
endmodule
`default_nettype wire

// File: tcr_timing_config_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module tcr_cfg_checker (
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic clock_enable_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic reg_rmw_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic move_start_in,
   input wire logic move_write_in,
   input wire logic move_onchip_in,
   input wire logic machine_cycle_in,
   input wire logic move_rd_n_out,
   input wire logic move_wr_n_out,
   input wire logic move_busy_out,
   input wire logic [7:0] port1_pins_in,
   input wire logic [7:0] port1_drive_out,
   input wire logic [7:0] analog_input_channels_out,
   input wire logic timer2_count_pin_out,
   input wire logic timer2_capture_trigger_out,
   input wire logic port0_pullup_enable_out,
   input wire logic timer0_tick_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);
   logic [3:0] mc_cnt_r;
   // Machine cycles spent busy; cleared between moves
   always_ff @(posedge clock_in) begin
      if (reset_in || !move_busy_out)
         mc_cnt_r <= 4'h0;
      else if (machine_cycle_in && clock_enable_in)
         mc_cnt_r <= mc_cnt_r + 4'h1;
   end
   // Idle in this cycle and the one before, so a start in the done cycle is left out
   sequence seq_move_start;
      move_start_in && clock_enable_in && !move_onchip_in && !move_busy_out && !$past(move_busy_out);
   endsequence
   sequence seq_strobe_low;
      move_busy_out && !(move_rd_n_out && move_wr_n_out);
   endsequence
   a_t0_tick_gap:
      assert property (timer0_tick_out |=> !timer0_tick_out [*3]) else $error("tick gap short");
   a_rmw_latch_read:
      assert property (reg_read_in && reg_rmw_in && clock_enable_in
         && reg_addr_in == tcr_pkg::TCR_ADDR_PORT1 |=> reg_rdata_out == $past(port1_drive_out))
         else $error("rmw read not latch");
   a_t2_pin_alias:
      assert property (timer2_count_pin_out == analog_input_channels_out[1]
         && timer2_capture_trigger_out == analog_input_channels_out[0]) else $error("pin alias");
   a_analog_pin_sync:
      assert property (!$past(reset_in) && !$past(reset_in, 2) && $past(clock_enable_in)
         && $past(clock_enable_in, 2)
         |-> analog_input_channels_out == $past(port1_pins_in, 2)) else $error("analog sync");
   a_pullup_write:
      assert property (reg_write_in && clock_enable_in && reg_addr_in == tcr_pkg::TCR_ADDR_PORT0_PULLUP
         |=> port0_pullup_enable_out == $past(reg_wdata_in[0])) else $error("pullup level");
   a_move_strobe_start:
      assert property (seq_move_start |=> seq_strobe_low ##0 move_wr_n_out != $past(move_write_in))
         else $error("strobe not started");
   a_onchip_no_strobe:
      assert property (move_onchip_in |-> move_rd_n_out && move_wr_n_out) else $error("onchip strobe");
   a_move_len_range:
      assert property ($fell(move_busy_out) |-> mc_cnt_r >= 4'h2 && mc_cnt_r <= 4'h9)
         else $error("move length");
endmodule
bind tcr_timing_config_regs tcr_cfg_checker u_chk (.clock_in, .reset_in, .clock_enable_in,
   .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rmw_in, .reg_rdata_out,
   .move_start_in, .move_write_in, .move_onchip_in, .machine_cycle_in, .move_rd_n_out,
   .move_wr_n_out, .move_busy_out, .port1_pins_in, .port1_drive_out, .analog_input_channels_out,
   .timer2_count_pin_out, .timer2_capture_trigger_out, .port0_pullup_enable_out, .timer0_tick_out);
`default_nettype wire

// File: tcr_timing_config_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module tcr_timing_config_regs_test;
   logic clock_in = 1'b0, reset_in = 1'b1, clock_enable_in = 1'b1, reg_write_in = 1'b0;
   logic reg_read_in = 1'b0, reg_rmw_in = 1'b0, timer1_count_hi_load_in = 1'b0;
   logic wdog_kick_in = 1'b0, move_start_in = 1'b0, move_write_in = 1'b0, move_onchip_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h0, reg_wdata_in = 8'h0, timer1_count_hi_in = 8'h0;
   logic [7:0] port1_pins_in = 8'h0, reg_rdata_out, port1_drive_out, analog_input_channels_out;
   logic machine_cycle_in, move_rd_n_out, move_wr_n_out, move_busy_out, timer2_count_pin_out;
   logic timer2_capture_trigger_out, port0_pullup_enable_out, timer0_tick_out, timer1_tick_out;
   logic timer2_tick_out, wdog_int_timeout_out, wdog_rst_timeout_out, irq_out, saw_wr;
   logic [3:0] busy_mc, strobe_mc;
   logic [7:0] d, ck;
   integer fails = 0, comparisons = 0, seed = 910, n, m;
   wire [2:0] ticks = {timer2_tick_out, timer1_tick_out, timer0_tick_out};
   tcr_timing_config_regs u_dut (.clock_in, .reset_in, .clock_enable_in, .reg_addr_in,
      .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rmw_in, .reg_rdata_out, .timer1_count_hi_in,
      .timer1_count_hi_load_in, .wdog_kick_in, .move_start_in, .move_write_in, .move_onchip_in,
      .machine_cycle_in, .move_rd_n_out, .move_wr_n_out, .move_busy_out, .port1_pins_in,
      .port1_drive_out, .analog_input_channels_out, .timer2_count_pin_out,
      .timer2_capture_trigger_out, .port0_pullup_enable_out, .timer0_tick_out, .timer1_tick_out,
      .timer2_tick_out, .wdog_int_timeout_out, .wdog_rst_timeout_out, .irq_out);
   tcr_ext_mem_model u_mem (.clock_in, .reset_in, .busy_in(move_busy_out),
      .rd_n_in(move_rd_n_out), .wr_n_in(move_wr_n_out), .machine_cycle_out(machine_cycle_in),
      .busy_mc_out(busy_mc), .strobe_mc_out(strobe_mc), .saw_wr_out(saw_wr));
   initial begin
      forever #20 clock_in = ~clock_in;
   end
   // ----------------------------------------
   // Expectations and bus tasks
   // ----------------------------------------
   function automatic logic [31:0] div_of(input logic sel);
      return sel ? 32'h4 : 32'hc;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_write_in <= 1'b1;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic rmw, input logic [7:0] exp);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rmw_in <= rmw;
      reg_read_in <= 1'b1;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      reg_rmw_in <= 1'b0;
      #1 chk(reg_rdata_out, exp);
   endtask
   task automatic gap(input int k, output int g);
      g = 0;
      do @(negedge clock_in); while (ticks[k] !== 1'b1);
      do begin
         @(negedge clock_in);
         g++;
      end while (ticks[k] !== 1'b1 && g < 40);
   endtask
   // Next start only once the done cycle has passed
   task automatic mv(input logic w, input logic oc);
      int t;
      @(posedge clock_in);
      move_write_in <= w;
      move_onchip_in <= oc;
      move_start_in <= 1'b1;
      @(posedge clock_in);
      move_start_in <= 1'b0;
      t = 0;
      #1;
      while (move_busy_out !== 1'b0 && t < 100) begin
         @(posedge clock_in);
         #1 t++;
      end
      chk(t < 100, 1'b1);
      repeat (2) @(posedge clock_in);
   endtask
   task automatic close_out;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Limit of 200000 cycles, above the run's watchdog wait of about 131k cycles
   initial begin
      #(200000 * 40);
      fails++;
      close_out;
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clock_in);
      reset_in <= 1'b0;
      rc(tcr_pkg::TCR_ADDR_TIMER1_UPPER, 1'b0, 8'h00);
      rc(tcr_pkg::TCR_ADDR_CLOCK_STRETCH, 1'b0, 8'h01);
      rc(tcr_pkg::TCR_ADDR_PORT0_PULLUP, 1'b0, 8'h00);
      chk(port0_pullup_enable_out, 1'b0);
      rc(tcr_pkg::TCR_ADDR_PORT1, 1'b1, 8'hff);
      chk(port1_drive_out, 8'hff);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         ck = (i == 0) ? 8'h01 : (i == 1) ? 8'h39 : {2'h0, d[5:3], 3'h1};
         wr(tcr_pkg::TCR_ADDR_CLOCK_STRETCH, ck);
         for (int k = 0; k < 3; k++) begin
            gap(k, n);
            chk(n, div_of(ck[3 + k]));
         end
      end
      $display("test prescale done");
      for (int i = 0; i < 2; i++) begin
         d = $random(seed);
         wr(tcr_pkg::TCR_ADDR_TIMER1_UPPER, d);
         rc(tcr_pkg::TCR_ADDR_TIMER1_UPPER, 1'b0, d);
         @(posedge clock_in);
         timer1_count_hi_in <= ~d;
         timer1_count_hi_load_in <= 1'b1;
         @(posedge clock_in);
         timer1_count_hi_load_in <= 1'b0;
         rc(tcr_pkg::TCR_ADDR_TIMER1_UPPER, 1'b0, ~d);
         @(posedge clock_in);
         clock_enable_in <= 1'b0;
         wr(tcr_pkg::TCR_ADDR_TIMER1_UPPER, d);
         clock_enable_in <= 1'b1;
         rc(tcr_pkg::TCR_ADDR_TIMER1_UPPER, 1'b0, ~d);
         wr(tcr_pkg::TCR_ADDR_PORT0_PULLUP, d ^ {7'h0, i[0]});
         rc(tcr_pkg::TCR_ADDR_PORT0_PULLUP, 1'b0, {7'h0, d[0] ^ i[0]});
         chk(port0_pullup_enable_out, d[0] ^ i[0]);
         ck = $random(seed);
         wr(tcr_pkg::TCR_ADDR_PORT1, ck);
         port1_pins_in <= d;
         repeat (3) @(posedge clock_in);
         rc(tcr_pkg::TCR_ADDR_PORT1, 1'b0, d);
         rc(tcr_pkg::TCR_ADDR_PORT1, 1'b1, ck);
         chk(port1_drive_out, ck);
         chk(analog_input_channels_out, d);
         chk({timer2_count_pin_out, timer2_capture_trigger_out}, d[1:0]);
      end
      $display("test registers done");
      wr(tcr_pkg::TCR_ADDR_IRQ_CLEAR, 8'h07);
      wr(tcr_pkg::TCR_ADDR_IRQ_ENABLE, 8'h04);
      for (int i = 0; i < 8; i++) begin
         wr(tcr_pkg::TCR_ADDR_CLOCK_STRETCH, i[7:0]);
         mv(i[0], 1'b0);
         chk(strobe_mc, i[3:0] + 4'h2);
         chk(saw_wr, i[0]);
      end
      mv(1'b0, 1'b1);
      chk({busy_mc, strobe_mc}, 8'h20);
      #1 chk(irq_out, 1'b1);
      rc(tcr_pkg::TCR_ADDR_IRQ_STATUS, 1'b0, 8'h04);
      wr(tcr_pkg::TCR_ADDR_IRQ_ENABLE, 8'h00);
      repeat (2) @(posedge clock_in);
      #1 chk(irq_out, 1'b0);
      wr(tcr_pkg::TCR_ADDR_IRQ_CLEAR, 8'h04);
      wr(tcr_pkg::TCR_ADDR_IRQ_STATUS, 8'hff);
      rc(tcr_pkg::TCR_ADDR_IRQ_STATUS, 1'b0, 8'h00);
      rc(8'h55, 1'b0, 8'h00);
      $display("test move done");
      wr(tcr_pkg::TCR_ADDR_CLOCK_STRETCH, 8'h01);
      wdog_kick_in <= 1'b1;
      @(posedge clock_in);
      wdog_kick_in <= 1'b0;
      n = 0;
      m = 0;
      while (wdog_int_timeout_out !== 1'b1 && n < 140000) begin
         @(negedge clock_in);
         n++;
      end
      chk(n >= 131071 && n <= 131073, 1'b1);
      do begin
         @(negedge clock_in);
         m++;
      end while (wdog_rst_timeout_out !== 1'b1 && m < 600);
      chk(m, 512);
      @(negedge clock_in);
      chk(wdog_rst_timeout_out, 1'b0);
      rc(tcr_pkg::TCR_ADDR_IRQ_STATUS, 1'b0, 8'h03);
      wr(tcr_pkg::TCR_ADDR_IRQ_CLEAR, 8'h03);
      rc(tcr_pkg::TCR_ADDR_IRQ_STATUS, 1'b0, 8'h00);
      $display("test watchdog done");
      close_out;
   end
endmodule
`default_nettype wire
